// [logic/sfo_fifo.sv]
// Deep synchronous FIFO core: storage, pointers, flags, offsets, replay.
// The write and read clocks arrive as pins and are turned into enable
// pulses on clk_in, which must run well above either of them.
`timescale 1ns/1ps

module sfo_fifo #(
    parameter int DEPTH = sfo_pkg::DEPTH_8K
) (
    input wire logic clk_in, // System clock, 10 MHz.
    input wire logic rst_in, // Synchronous reset, active high.
    input wire logic master_clear_n_in, // Master clear pin, active low.
    input wire logic write_clk_in, // Write clock pin.
    input wire logic read_clk_in, // Read clock pin.
    input wire logic write_en_n_in, // Write enable, active low.
    input wire logic read_en_n_in, // Read enable, active low.
    input wire logic offset_load_select_n_in, // Offset access select, active low.
    input wire logic [sfo_pkg::DATA_W-1:0] data_in, // Write data pins.
    input wire logic replay_pulse_in, // Retransmit pulse, active high.
    input wire logic flag_sync_mode_n_in, // Low: almost flags are clocked.
    input wire logic depth_expansion_in, // High when used in depth expansion.
    output logic [sfo_pkg::DATA_W-1:0] data_out, // Read data, registered.
    output logic full_flag_n_out, // Full, active low.
    output logic almost_full_flag_n_out, // Almost full, active low.
    output logic half_level_flag_n_out, // More than half full, active low.
    output logic almost_empty_flag_n_out, // Almost empty, active low.
    output logic empty_flag_n_out // Empty, active low.
);
    import sfo_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] HALF_C = CNT_W'(DEPTH / 2);
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [AW:0] PTR_ZERO = '0;
    localparam logic [AW:0] PTR_ONE = (AW + 1)'(1);

    sfo_pins_s pins_raw;
    sfo_pins_s pins;
    sfo_pins_s rise;

    // Gather every pin so the whole group sees the same two-stage delay,
    // which keeps data and enables aligned with the clock edges.
    assign pins_raw = '{
        mclr_n: master_clear_n_in,
        depth_exp: depth_expansion_in,
        flag_sync_mode_n: flag_sync_mode_n_in,
        rt: replay_pulse_in,
        ld_n: offset_load_select_n_in,
        wen_n: write_en_n_in,
        ren_n: read_en_n_in,
        wclk: write_clk_in,
        rclk: read_clk_in,
        data: data_in
    };

    sfo_pin_sync #(
        .WIDTH($bits(sfo_pins_s)),
        .RESET_VAL(PINS_IDLE)
    ) u_pin_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(pins_raw),
        .q_out(pins),
        .rise_out(rise)
    );

    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [OFS_W-1:0] almost_empty_distance;
    logic [OFS_W-1:0] almost_full_distance;
    sfo_sel_e wr_sel;
    sfo_sel_e rd_sel;
    sfo_flags_s flags;
    sfo_flags_s next_flags;

    wire clear = rst_in | ~pins.mclr_n;
    wire wr_edge = rise.wclk;
    wire rd_edge = rise.rclk;
    wire [OFS_W-1:0] data_in_low_bits = pins.data[OFS_W-1:0];

    // Both ports decode their operation the same way.
    sfo_op_e wr_op;
    sfo_op_e rd_op;
    assign wr_op = sfo_decode(pins.ld_n, pins.wen_n);
    assign rd_op = sfo_decode(pins.ld_n, pins.ren_n);

    // A data write needs the full flag high; a data read needs empty high.
    // The registered flags are used, not the live count, as on the device.
    wire wr_data_go = wr_edge & (wr_op == SFO_OP_DATA) & flags.full_n;
    wire wr_prog_go = wr_edge & (wr_op == SFO_OP_PROG);
    wire rd_data_go = rd_edge & (rd_op == SFO_OP_DATA) & flags.empty_n;
    wire rd_prog_go = rd_edge & (rd_op == SFO_OP_PROG);

    // Replay is ignored when the part sits in a depth-expansion chain.
    wire replay_go = rise.rt & ~pins.depth_exp;

    // Pointer arithmetic carries one extra bit so full and empty differ.
    logic [AW:0] next_wptr;
    logic [AW:0] next_rptr;
    logic [CNT_W-1:0] next_count;
    assign next_wptr = wr_data_go ? wptr + PTR_ONE : wptr;
    assign next_rptr = replay_go ? PTR_ZERO
                     : (rd_data_go ? rptr + PTR_ONE : rptr);
    assign next_count = CNT_W'(next_wptr - next_rptr);

    // Threshold compares; offsets are zero-extended to count width.
    logic [CNT_W-1:0] ae_limit;
    logic [CNT_W-1:0] af_limit;
    assign ae_limit = CNT_W'(almost_empty_distance);
    assign af_limit = DEPTH_C - CNT_W'(almost_full_distance);

    // Flag levels for the occupancy after this cycle's operations.
    // The table scales with DEPTH, so one set of compares covers both sizes.
    assign next_flags.full_n = (next_count != DEPTH_C);
    assign next_flags.almost_full_n = (next_count < af_limit);
    assign next_flags.half_n = (next_count <= HALF_C);
    assign next_flags.almost_empty_n = (next_count > ae_limit);
    assign next_flags.empty_n = (next_count != CNT_ZERO);

    // In clocked mode the almost flags wait for their own clock edge;
    // otherwise they follow the pointers on every system cycle.
    wire af_update = pins.flag_sync_mode_n | wr_edge;
    wire ae_update = pins.flag_sync_mode_n | rd_edge;

    // Storage write; no reset, so contents are undefined until written.
    always_ff @(posedge clk_in) begin
        if (wr_data_go) begin
            mem[wptr[AW-1:0]] <= pins.data;
        end
    end

    // Pointers; clear leaves the FIFO empty.
    always_ff @(posedge clk_in) begin
        if (clear) begin
            wptr <= PTR_ZERO;
            rptr <= PTR_ZERO;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
        end
    end

    // All flags live in one process so the register has a single driver.
    // Full moves only with the write clock, empty only with the read clock,
    // the almost flags follow the mode pin and half-level is never clocked.
    always_ff @(posedge clk_in) begin
        if (clear) begin
            flags <= FLAGS_RESET;
        end else begin
            if (wr_edge) begin
                flags.full_n <= next_flags.full_n;
            end
            if (rd_edge) begin
                flags.empty_n <= next_flags.empty_n;
            end
            if (af_update) begin
                flags.almost_full_n <= next_flags.almost_full_n;
            end
            if (ae_update) begin
                flags.almost_empty_n <= next_flags.almost_empty_n;
            end
            flags.half_n <= next_flags.half_n;
        end
    end

    // Offset programming: each programming write loads the selected
    // register and steps the sequence, so writes alternate.
    always_ff @(posedge clk_in) begin
        if (clear) begin
            almost_empty_distance <= OFS_DEFAULT;
            almost_full_distance <= OFS_DEFAULT;
            wr_sel <= SFO_SEL_EMPTY;
        end else if (wr_prog_go) begin
            unique case (wr_sel)
                SFO_SEL_EMPTY: begin
                    almost_empty_distance <= data_in_low_bits;
                    wr_sel <= SFO_SEL_FULL;
                end
                SFO_SEL_FULL: begin
                    almost_full_distance <= data_in_low_bits;
                    wr_sel <= SFO_SEL_EMPTY;
                end
            endcase
        end
        // Outside a programming write the position is simply held.
    end

    // Read-side sequence pointer for offset read-back.
    // It is kept apart from the write sequence so that reading the
    // offsets never disturbs where the next programming write lands.
    always_ff @(posedge clk_in) begin
        if (clear) begin
            rd_sel <= SFO_SEL_EMPTY;
        end else if (rd_prog_go) begin
            rd_sel <= (rd_sel == SFO_SEL_EMPTY) ? SFO_SEL_FULL : SFO_SEL_EMPTY;
        end
    end

    // Offset value presented on a read-back, zero-extended to data width.
    logic [DATA_W-1:0] offset_word;
    assign offset_word = (rd_sel == SFO_SEL_EMPTY)
                       ? DATA_W'(almost_empty_distance)
                       : DATA_W'(almost_full_distance);

    // Output register changes only on a taken read; a blocked read on an
    // empty FIFO leaves the last word in place.
    always_ff @(posedge clk_in) begin
        if (clear) begin
            data_out <= DATA_RESET;
        end else if (rd_data_go) begin
            data_out <= mem[rptr[AW-1:0]];
        end else if (rd_prog_go) begin
            data_out <= offset_word;
        end
        // Otherwise hold.
    end

    // Flag pins come straight from their registers.
    assign full_flag_n_out = flags.full_n;
    assign almost_full_flag_n_out = flags.almost_full_n;
    assign half_level_flag_n_out = flags.half_n;
    assign almost_empty_flag_n_out = flags.almost_empty_n;
    assign empty_flag_n_out = flags.empty_n;

endmodule

// [logic/sfo_pkg.sv]
// Shared constants, types and decode helpers for the deep synchronous FIFO.
// Assumes a single 10 MHz system clock; all device pins are sampled on it.
//
// Operation
// - Two 14-bit offsets loaded from low data bits.
// - Offsets set distance of almost flags from boundaries.
// - First programming write edge loads almost-empty offset.
// - Second programming write edge loads almost-full offset.
// - Third programming write wraps to almost-empty offset.
// - Sequence position survives return to normal operation.
// - Programming reads return offsets in same alternating order.
// - Load select and write enable choose the operation.
// - Full flag low when full; blocks data writes.
// - Full flag changes only on write clock edges.
// - Empty flag low when empty; blocks data reads.
// - Empty flag changes only on read clock edges.
// - Sync mode: almost flags follow their own clocks.
// - 8K depth flag thresholds follow occupancy table.
// - 16K depth thresholds scale with depth, same low end.
// - Unprogrammed offsets default to 127 words.
// - Replay pulse rewinds read pointer to location zero.
// - Replay honoured only outside depth expansion.
// - After replay, reads repeat data up to write pointer.
// - Flags recomputed from pointers during and after replay.
// - Reset empties the FIFO with empty flag low.
// - Empty FIFO keeps last read data on outputs.
package sfo_pkg;

    localparam int DATA_W = 18;
    localparam int OFS_W = 14;
    localparam int CNT_W = 16;
    localparam int DEPTH_8K = 8192;
    localparam int DEPTH_16K = 16384;
    localparam logic [OFS_W-1:0] OFS_DEFAULT = 14'h007f;
    localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;

    // Which offset register the programming sequence points at.
    typedef enum logic {
        SFO_SEL_EMPTY = 1'b0,
        SFO_SEL_FULL = 1'b1
    } sfo_sel_e;

    // Operation chosen by load select and an enable on a clock edge.
    typedef enum logic [1:0] {
        SFO_OP_NONE = 2'b00,
        SFO_OP_PROG = 2'b01,
        SFO_OP_DATA = 2'b10
    } sfo_op_e;

    // All device pins, carried together through the synchroniser.
    typedef struct packed {
        logic mclr_n;
        logic depth_exp;
        logic flag_sync_mode_n;
        logic rt;
        logic ld_n;
        logic wen_n;
        logic ren_n;
        logic wclk;
        logic rclk;
        logic [DATA_W-1:0] data;
    } sfo_pins_s;

    localparam sfo_pins_s PINS_IDLE = '{
        mclr_n: 1'b1, depth_exp: 1'b0, flag_sync_mode_n: 1'b0, rt: 1'b0, ld_n: 1'b1,
        wen_n: 1'b1, ren_n: 1'b1, wclk: 1'b0, rclk: 1'b0, data: DATA_RESET
    };

    // Status flags, all active low as on the device pins.
    typedef struct packed {
        logic full_n;
        logic almost_full_n;
        logic half_n;
        logic almost_empty_n;
        logic empty_n;
    } sfo_flags_s;

    localparam sfo_flags_s FLAGS_RESET = '{
        full_n: 1'b1, almost_full_n: 1'b1, half_n: 1'b1,
        almost_empty_n: 1'b0, empty_n: 1'b0
    };

    // Shared by the write and read ports: load select low means the offsets.
    function automatic sfo_op_e sfo_decode(input logic ld_n, input logic en_n);
        if (en_n) begin
            return SFO_OP_NONE;
        end else if (ld_n) begin
            return SFO_OP_DATA;
        end
        return SFO_OP_PROG;
    endfunction

endpackage

// [logic/sfo_pin_sync.sv]
// Two-stage pin synchroniser with rising-edge detection per bit.
// Assumes every input bit is asynchronous to clk_in.
`timescale 1ns/1ps

module sfo_pin_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_in, // System clock.
    input wire logic rst_in, // Synchronous reset, active high.
    input wire logic [WIDTH-1:0] d_in, // Raw pin levels.
    output logic [WIDTH-1:0] q_out, // Synchronised levels.
    output logic [WIDTH-1:0] rise_out // One-cycle pulse on a rising level.
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // The first stage feeds only the second, so metastability never spreads.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end else begin
            stage1 <= d_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Edges are taken between the second and third stage.
    assign q_out = stage2;
    assign rise_out = stage2 & ~stage3;

endmodule

// [bench/sfo_fifo_asserts.sv]
// Checker for sfo_fifo flag and read-data timing, bound to every instance.
// Assumes each pin clock stays high for at least three system clocks.
`timescale 1ns/1ps

module sfo_fifo_asserts (
    input wire logic clk_in, // Clock.
    input wire logic rst_in, // Reset.
    input wire logic master_clear_n_in, // Clear pin.
    input wire logic write_clk_in, // Write clock.
    input wire logic read_clk_in, // Read clock.
    input wire logic offset_load_select_n_in, // Load select.
    input wire logic flag_sync_mode_n_in, // Flag mode.
    input wire logic [sfo_pkg::DATA_W-1:0] data_out, // Read data.
    input wire logic full_flag_n_out, // Full.
    input wire logic almost_full_flag_n_out, // Almost full.
    input wire logic half_level_flag_n_out, // Half.
    input wire logic almost_empty_flag_n_out, // Almost empty.
    input wire logic empty_flag_n_out // Empty.
);
    import sfo_pkg::*;
    logic [5:0] wc_h, rc_h, mc_h, ld_h;
    wire sfo_flags_s flags = {full_flag_n_out, almost_full_flag_n_out,
        half_level_flag_n_out, almost_empty_flag_n_out, empty_flag_n_out};
    // Pin histories; the synchroniser delay is traced over a window, not one exact cycle.
    always_ff @(posedge clk_in) begin
        wc_h <= {wc_h[4:0], write_clk_in};
        rc_h <= {rc_h[4:0], read_clk_in};
        mc_h <= {mc_h[4:0], master_clear_n_in};
        ld_h <= {ld_h[4:0], offset_load_select_n_in};
    end
    // Calm means no master clear is still working its way through the pins.
    wire calm = (&mc_h) && master_clear_n_in;
    wire wr_seen = |wc_h;
    wire rd_seen = |rc_h;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    full_edge_a: assert property ($changed(full_flag_n_out) && calm |-> wr_seen)
        else $error("full flag moved without a write clock");
    empty_edge_a: assert property ($changed(empty_flag_n_out) && calm |-> rd_seen)
        else $error("empty flag moved without a read clock");
    af_sync_a: assert property ($changed(almost_full_flag_n_out) &&
        !flag_sync_mode_n_in && calm |-> wr_seen)
        else $error("almost full moved off its clock");
    ae_sync_a: assert property ($changed(almost_empty_flag_n_out) &&
        !flag_sync_mode_n_in && calm |-> rd_seen)
        else $error("almost empty moved off its clock");
    clear_flags_a: assert property (!master_clear_n_in [*5] |->
        flags == FLAGS_RESET && data_out == DATA_RESET)
        else $error("clear did not empty the fifo");
    full_sets_a: assert property ($fell(full_flag_n_out) |->
        !almost_full_flag_n_out && !half_level_flag_n_out)
        else $error("full without almost full and half");
    empty_sets_a: assert property ($fell(empty_flag_n_out) && calm |->
        ##[0:1] !almost_empty_flag_n_out)
        else $error("empty without almost empty");
    hold_empty_a: assert property (!empty_flag_n_out && calm && (&ld_h) |=>
        $stable(data_out))
        else $error("read data moved while empty");
    data_edge_a: assert property ($changed(data_out) && calm |-> rd_seen)
        else $error("read data moved without a read clock");
    cover property (!full_flag_n_out);
    cover property ($fell(empty_flag_n_out) && calm);
    cover property ($changed(almost_empty_flag_n_out) && !flag_sync_mode_n_in);
endmodule

bind sfo_fifo sfo_fifo_asserts u_chk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .master_clear_n_in(master_clear_n_in),
    .write_clk_in(write_clk_in),
    .read_clk_in(read_clk_in),
    .offset_load_select_n_in(offset_load_select_n_in),
    .flag_sync_mode_n_in(flag_sync_mode_n_in),
    .data_out(data_out),
    .full_flag_n_out(full_flag_n_out),
    .almost_full_flag_n_out(almost_full_flag_n_out),
    .half_level_flag_n_out(half_level_flag_n_out),
    .almost_empty_flag_n_out(almost_empty_flag_n_out),
    .empty_flag_n_out(empty_flag_n_out)
);

// [bench/sfo_host_model.sv]
// Host model: writer and reader logic driving the FIFO pins.
// Assumes clk_in is the system clock that samples every pin.
`timescale 1ns/1ps

module sfo_host_model (
    input wire logic clk_in, // System clock.
    output logic write_clk_out, // Write clock pin.
    output logic read_clk_out, // Read clock pin.
    output logic write_en_n_out, // Write enable.
    output logic read_en_n_out, // Read enable.
    output logic load_n_out, // Load select.
    output logic [sfo_pkg::DATA_W-1:0] data_out, // Write data.
    output logic replay_out // Retransmit pulse.
);
    import sfo_pkg::*;
    // Idle pins at time zero.
    initial begin
        write_clk_out = 1'b0;
        read_clk_out = 1'b0;
        write_en_n_out = 1'b1;
        read_en_n_out = 1'b1;
        load_n_out = 1'b1;
        data_out = '0;
        replay_out = 1'b0;
    end
    // One pin clock; controls hold three periods each side since the device synchronises them.
    task automatic pin_cycle(input logic wr, input logic ld_n, input logic en_n,
        input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        #1;
        load_n_out = ld_n;
        data_out = d;
        write_en_n_out = wr ? en_n : 1'b1;
        read_en_n_out = wr ? 1'b1 : en_n;
        repeat (3) @(posedge clk_in);
        #1;
        write_clk_out = wr;
        read_clk_out = !wr;
        repeat (3) @(posedge clk_in);
        #1;
        write_clk_out = 1'b0;
        read_clk_out = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        write_en_n_out = 1'b1;
        read_en_n_out = 1'b1;
        load_n_out = 1'b1;
        data_out = ~d;
    endtask
    // Retransmit pulse with both enables idle before, during and after it.
    task automatic replay();
        @(posedge clk_in);
        #1;
        replay_out = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        replay_out = 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// [bench/sync_fifo_offset_flags_retransmit_test.sv]
// Self-checking bench for sfo_fifo at a reduced depth of 512 words.
// Assumes the host model owns every pin except clock, reset and straps.
`timescale 1ns/1ps

module sync_fifo_offset_flags_retransmit_test;
    import sfo_pkg::*;
    localparam int D = 512;
    localparam int N = 6;
    localparam int M = 10;
    logic clk_in, rst_in, clear_n, mode_n, dexp;
    wire wclk, rclk, wen_n, ren_n, ld_n, rt;
    wire [DATA_W-1:0] din, dout;
    wire sfo_flags_s fl;
    int miscompares = 0;
    int n_checks = 0;

    sfo_fifo #(.DEPTH(D)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .master_clear_n_in(clear_n),
        .write_clk_in(wclk), .read_clk_in(rclk), .write_en_n_in(wen_n), .read_en_n_in(ren_n),
        .offset_load_select_n_in(ld_n), .data_in(din), .replay_pulse_in(rt),
        .flag_sync_mode_n_in(mode_n), .depth_expansion_in(dexp), .data_out(dout),
        .full_flag_n_out(fl.full_n), .almost_full_flag_n_out(fl.almost_full_n),
        .half_level_flag_n_out(fl.half_n), .almost_empty_flag_n_out(fl.almost_empty_n),
        .empty_flag_n_out(fl.empty_n)
    );
    // One host drives every clock, enable, load, data and retransmit pin, as slices of a wider word would share them.
    sfo_host_model u_host (
        .clk_in(clk_in), .write_clk_out(wclk), .read_clk_out(rclk), .write_en_n_out(wen_n),
        .read_en_n_out(ren_n), .load_n_out(ld_n), .data_out(din), .replay_out(rt)
    );
    // 10 MHz system clock.
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // Watchdog; a hang counts as a mismatch.
    initial begin
        repeat (100000) @(posedge clk_in);
        miscompares++;
        complete_run();
    end
    task automatic check(input string what, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Word pattern, distinct for every index and with the high bits in use.
    function automatic logic [DATA_W-1:0] wd(input int i);
        return DATA_W'(i) ^ 18'h2a5a5;
    endfunction
    // Expected flags for an occupancy, in sfo_flags_s order, all active low.
    function automatic logic [4:0] exp_fl(input int c);
        return {c != D, c < D - M, c <= D / 2, c > N, c != 0};
    endfunction
    function automatic bit edge_cnt(input int c);
        return c inside {0, 1, N, N + 1, D / 2, D / 2 + 1, D - M - 1, D - M, D};
    endfunction
    // Both pin clocks with enables high, so every clocked flag is refreshed first.
    task automatic flags_at(input int c);
        u_host.pin_cycle(1'b1, 1'b1, 1'b1, '0);
        u_host.pin_cycle(1'b0, 1'b1, 1'b1, '0);
        check("flags", DATA_W'(fl), DATA_W'(exp_fl(c)));
    endtask
    task automatic wr(input logic [DATA_W-1:0] d);
        u_host.pin_cycle(1'b1, 1'b1, 1'b0, d);
    endtask
    task automatic rd(input logic [DATA_W-1:0] exp);
        u_host.pin_cycle(1'b0, 1'b1, 1'b0, '0);
        check("read data", dout, exp);
    endtask
    task automatic ofs_check(input logic [OFS_W-1:0] ae, input logic [OFS_W-1:0] af);
        u_host.pin_cycle(1'b0, 1'b0, 1'b0, '0);
        check("ae offset", dout, DATA_W'(ae));
        u_host.pin_cycle(1'b0, 1'b0, 1'b0, '0);
        check("af offset", dout, DATA_W'(af));
    endtask
    // Offsets, fill and drain across every flag boundary, master clear, then replay.
    initial begin
        rst_in = 1'b1;
        clear_n = 1'b1;
        mode_n = 1'b0;
        dexp = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        check("reset flags", DATA_W'(fl), DATA_W'(FLAGS_RESET));
        check("reset data", dout, DATA_RESET);
        ofs_check(OFS_DEFAULT, OFS_DEFAULT);
        u_host.pin_cycle(1'b1, 1'b0, 1'b0, 18'h3c04d);
        u_host.pin_cycle(1'b1, 1'b0, 1'b1, 18'h00009);
        u_host.pin_cycle(1'b1, 1'b0, 1'b0, 18'h3c00a);
        u_host.pin_cycle(1'b1, 1'b0, 1'b0, 18'h3c006);
        ofs_check(14'h0006, 14'h000a);
        for (int i = 0; i < D; i++) begin
            wr(wd(i));
            if (edge_cnt(i + 1)) begin
                flags_at(i + 1);
            end
        end
        wr(18'h3ffff);
        for (int i = 0; i < D; i++) begin
            rd(wd(i));
            if (edge_cnt(D - 1 - i)) begin
                flags_at(D - 1 - i);
            end
        end
        rd(wd(D - 1));
        mode_n = 1'b1;
        // Master clear first, so the replay below sees no more writes than the depth.
        clear_n = 1'b0;
        repeat (6) @(posedge clk_in);
        #1;
        clear_n = 1'b1;
        check("clear flags", DATA_W'(fl), DATA_W'(FLAGS_RESET));
        check("clear data", dout, DATA_RESET);
        u_host.pin_cycle(1'b1, 1'b0, 1'b0, DATA_W'(N));
        ofs_check(OFS_W'(N), OFS_DEFAULT);
        for (int i = 0; i < 3; i++) begin
            wr(wd(i + 700));
        end
        rd(DATA_W'(OFS_DEFAULT));
        for (int i = 0; i < 3; i++) begin
            rd(wd(i + 700));
        end
        u_host.replay();
        flags_at(3);
        for (int i = 0; i < 3; i++) begin
            rd(wd(i + 700));
        end
        wr(wd(703));
        rd(wd(702));
        rd(wd(703));
        wr(wd(704));
        wr(wd(705));
        rd(wd(703));
        rd(wd(704));
        dexp = 1'b1;
        u_host.replay();
        rd(wd(705));
        dexp = 1'b0;
        complete_run();
    end
endmodule
